// File: rtl/rfb_top.sv
// Reader FIFO, watermark alerts and bit framing behind AXI4-Lite.
// Assumes the radio bit ports are driven by logic on aclk.
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/10ps
module rfb_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             irq,
  output logic             timer_start_strobe,
  output logic             timer_stop_strobe,
  output logic             tx_bit,
  output logic             tx_bit_valid,
  input  wire logic        tx_bit_ready,
  input  wire logic        rx_bit,
  input  wire logic        rx_bit_valid,
  input  wire logic        rx_end,
  output logic [2:0]       modem_state_c
);
  // ----------------------------------------------------------------
  // Storage and state
  // ----------------------------------------------------------------
  logic [7:0]                 mem_r [rfb_pkg::DEPTH];
  logic [rfb_pkg::PTR_W-1:0]  wr_ptr_r, rd_ptr_r;
  logic [6:0]                 fifo_count_r;
  logic                       buffer_overflow_error_r;
  logic [5:0]                 watermark_level_r;
  logic [2:0]                 rx_valid_last_bits_r;
  logic [2:0]                 rx_bit_alignment_r;
  logic [2:0]                 tx_last_bits_b_r;
  logic                       transceive_r;
  logic [rfb_pkg::IRQ_W-1:0]  istat_r, imask_r;
  logic                       hi_d_r, lo_d_r;
  rfb_pkg::rfb_state_type     state_r;
  logic [7:0]                 tx_sh_r, rx_sh_r;
  logic [3:0]                 tx_cnt_r;
  logic [2:0]                 rx_pos_r;
  logic                       aw_h_r, w_h_r;
  logic [11:0]                aw_addr_r;
  logic [31:0]                w_data_r;
  logic [3:0]                 w_strb_r;

  // ----------------------------------------------------------------
  // Decode and FIFO control terms
  // ----------------------------------------------------------------
  logic       do_wr, do_rd, wr_ok;
  logic [7:0] wr_idx, rd_idx, wbyte, rx_byte;
  logic       host_push, host_pop, flush, start_send_a;
  logic       rx_push, tx_pop, push, pop, push_ok, pop_ok, full, empty;
  logic       high_alert, low_alert, rx_done;
  logic [6:0] free_space;

  assign wr_idx  = rfb_pkg::rfb_index(aw_addr_r);
  assign rd_idx  = rfb_pkg::rfb_index(s_axi_araddr);
  assign wbyte   = w_data_r[7:0];
  assign full    = (fifo_count_r == rfb_pkg::FULL_CNT);
  assign empty   = (fifo_count_r == 7'h00);
  // Host write performed once address and data are both held, no response is pending and no rx push is in the cycle
  assign do_wr   = aw_h_r && w_h_r && !s_axi_bvalid && !rx_push;
  assign wr_ok   = do_wr && w_strb_r[0];
  assign do_rd   = s_axi_arvalid && s_axi_arready;
  assign host_push = wr_ok && (wr_idx == rfb_pkg::IDX_DATA);
  assign host_pop  = do_rd && (rd_idx == rfb_pkg::IDX_DATA);
  assign flush   = wr_ok && (wr_idx == rfb_pkg::IDX_LEVEL)
                   && wbyte[rfb_pkg::FLUSH_BIT];
  assign start_send_a = wr_ok && (wr_idx == rfb_pkg::IDX_FRAME)
                   && wbyte[rfb_pkg::SEND_BIT];
  assign push    = host_push || rx_push;
  assign pop     = host_pop || tx_pop;
  assign push_ok = push && !full;
  assign pop_ok  = pop && !empty;
  assign free_space = rfb_pkg::FULL_CNT - fifo_count_r;
  assign high_alert = free_space <= {1'b0, watermark_level_r};
  assign low_alert  = fifo_count_r <= {1'b0, watermark_level_r};

  // ----------------------------------------------------------------
  // FIFO pointers, count and overflow flag
  // ----------------------------------------------------------------
  // Pointers and count, flush has priority
  always_ff @(posedge aclk) begin
    if (!aresetn || flush) begin
      wr_ptr_r     <= '0;
      rd_ptr_r     <= '0;
      fifo_count_r <= '0;
    end else begin
      if (push_ok) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop_ok) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
      case ({push_ok, pop_ok})
        2'b10:   fifo_count_r <= fifo_count_r + 7'h01;
        2'b01:   fifo_count_r <= fifo_count_r - 7'h01;
        default: fifo_count_r <= fifo_count_r;
      endcase
    end
  end

  // Byte storage
  always_ff @(posedge aclk) begin
    if (push_ok) begin
      mem_r[wr_ptr_r] <= host_push ? wbyte : rx_byte;
    end
  end

  // Overflow error, push to full FIFO sets it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      buffer_overflow_error_r <= 1'b0;
    end else if (push && full) begin
      buffer_overflow_error_r <= 1'b1;
    end else if (flush) begin
      buffer_overflow_error_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Software controlled registers
  // ----------------------------------------------------------------
  // Watermark, framing fields, transceive, mask
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      watermark_level_r  <= rfb_pkg::WATER_RST;
      rx_bit_alignment_r <= '0;
      tx_last_bits_b_r   <= '0;
      transceive_r       <= 1'b0;
      imask_r            <= '0;
    end else if (wr_ok) begin
      if (wr_idx == rfb_pkg::IDX_WATER) begin
        watermark_level_r <= wbyte[5:0];
      end else if (wr_idx == rfb_pkg::IDX_FRAME) begin
        rx_bit_alignment_r <= wbyte[rfb_pkg::ALIGN_LSB +: 3];
        tx_last_bits_b_r   <= wbyte[2:0];
      end else if (wr_idx == rfb_pkg::IDX_MODEM) begin
        transceive_r <= wbyte[rfb_pkg::XCV_BIT];
      end else if (wr_idx == rfb_pkg::IDX_IMASK) begin
        imask_r <= wbyte[rfb_pkg::IRQ_W-1:0];
      end
    end
  end

  // Timer strobes, one cycle each
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_start_strobe <= 1'b0;
      timer_stop_strobe  <= 1'b0;
    end else begin
      timer_stop_strobe  <= wr_ok && (wr_idx == rfb_pkg::IDX_CTRL)
                            && wbyte[rfb_pkg::STOP_BIT];
      timer_start_strobe <= wr_ok && (wr_idx == rfb_pkg::IDX_CTRL)
                            && wbyte[rfb_pkg::START_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Modem sequencer: wait, transmit, receive
  // ----------------------------------------------------------------
  assign tx_pop       = (state_r == rfb_pkg::ST_TX) && (tx_cnt_r == 4'h0)
                        && !empty;
  assign tx_bit_valid = (state_r == rfb_pkg::ST_TX) && (tx_cnt_r != 4'h0);
  assign tx_bit       = tx_sh_r[0];
  assign modem_state_c = rfb_pkg::rfb_code(state_r);

  // Receive byte with the incoming bit put in place
  always_comb begin
    rx_byte = rx_sh_r;
    if (rx_bit_valid) begin
      rx_byte[rx_pos_r] = rx_bit;
    end
  end
  assign rx_push = ((state_r == rfb_pkg::ST_RXWAIT) ||
                    (state_r == rfb_pkg::ST_RX)) &&
                   ((rx_bit_valid && (rx_pos_r == 3'h7)) ||
                    (!rx_bit_valid && rx_end &&
                     (state_r == rfb_pkg::ST_RX) && (rx_pos_r != 3'h0)));
  assign rx_done = (state_r == rfb_pkg::ST_RX) && !rx_bit_valid && rx_end;

  // State transitions
  always_ff @(posedge aclk) begin
    if (!aresetn || !transceive_r) begin
      state_r <= rfb_pkg::ST_IDLE;
    end else begin
      case (state_r)
        rfb_pkg::ST_IDLE:   state_r <= rfb_pkg::ST_WAIT;
        rfb_pkg::ST_WAIT: begin
          if (start_send_a) begin
            state_r <= rfb_pkg::ST_TX;
          end
        end
        rfb_pkg::ST_TX: begin
          if (tx_cnt_r == 4'h0 && empty) begin
            state_r <= rfb_pkg::ST_RXWAIT;
          end
        end
        rfb_pkg::ST_RXWAIT: begin
          if (rx_bit_valid) begin
            state_r <= rfb_pkg::ST_RX;
          end
        end
        rfb_pkg::ST_RX: begin
          if (rx_done) begin
            state_r <= rfb_pkg::ST_WAIT;
          end
        end
        default: state_r <= rfb_pkg::ST_IDLE;
      endcase
    end
  end

  // Transmit shifter, final byte cut to the last-bits count
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_sh_r  <= '0;
      tx_cnt_r <= '0;
    end else if (tx_pop) begin
      tx_sh_r  <= mem_r[rd_ptr_r];
      tx_cnt_r <= (fifo_count_r == 7'h01 && tx_last_bits_b_r != 3'h0)
                  ? {1'b0, tx_last_bits_b_r} : 4'h8;
    end else if (tx_bit_valid && tx_bit_ready) begin
      tx_sh_r  <= {1'b0, tx_sh_r[7:1]};
      tx_cnt_r <= tx_cnt_r - 4'h1;
    end
  end

  // Receive assembler, starts at the alignment position
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_sh_r              <= '0;
      rx_pos_r             <= '0;
      rx_valid_last_bits_r <= '0;
    end else if (state_r == rfb_pkg::ST_TX) begin
      rx_sh_r  <= '0;
      rx_pos_r <= rx_bit_alignment_r;
    end else if (rx_bit_valid && (state_r == rfb_pkg::ST_RXWAIT ||
                                  state_r == rfb_pkg::ST_RX)) begin
      rx_sh_r  <= (rx_pos_r == 3'h7) ? 8'h00 : rx_byte;
      rx_pos_r <= rx_pos_r + 3'h1;
    end else if (rx_done) begin
      rx_valid_last_bits_r <= rx_pos_r;
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  logic [rfb_pkg::IRQ_W-1:0] iset, iclr;
  always_comb begin
    iset = '0;
    iset[rfb_pkg::IRQ_OVFL]   = push && full;
    iset[rfb_pkg::IRQ_HI]     = high_alert && !hi_d_r;
    iset[rfb_pkg::IRQ_LO]     = low_alert && !lo_d_r;
    iset[rfb_pkg::IRQ_RXDONE] = rx_done;
    iclr = (wr_ok && wr_idx == rfb_pkg::IDX_ISTAT)
           ? wbyte[rfb_pkg::IRQ_W-1:0] : '0;
  end

  // Sticky status, a new event beats a clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      istat_r <= '0;
      hi_d_r  <= 1'b0;
      lo_d_r  <= 1'b0;
      irq     <= 1'b0;
    end else begin
      istat_r <= (istat_r & ~iclr) | iset;
      hi_d_r  <= high_alert;
      lo_d_r  <= low_alert;
      irq     <= |(((istat_r & ~iclr) | iset) & imask_r);
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  assign s_axi_awready = !aw_h_r;
  assign s_axi_wready  = !w_h_r;
  assign s_axi_arready = !s_axi_rvalid && !tx_pop;

  // Write channel holding and response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_h_r <= 1'b0;
      w_h_r  <= 1'b0;
      aw_addr_r <= '0;
      w_data_r  <= '0;
      w_strb_r  <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= rfb_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_h_r    <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_h_r    <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_h_r <= 1'b0;
        w_h_r  <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr_r[11:10] == 2'h0 &&
          ((wr_idx >= rfb_pkg::IDX_DATA && wr_idx <= rfb_pkg::IDX_FRAME)
           || (wr_idx >= rfb_pkg::IDX_ISTAT &&
               wr_idx <= rfb_pkg::IDX_MODEM)))
          ? rfb_pkg::RESP_OKAY : rfb_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read mux and response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= rfb_pkg::RESP_OKAY;
    end else if (do_rd) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= rfb_pkg::RESP_OKAY;
      s_axi_rdata  <= '0;
      if (s_axi_araddr[11:10] != 2'h0) begin
        s_axi_rresp <= rfb_pkg::RESP_SLVERR;
      end else if (rd_idx == rfb_pkg::IDX_DATA) begin
        s_axi_rdata[7:0] <= empty ? 8'h00 : mem_r[rd_ptr_r];
      end else if (rd_idx == rfb_pkg::IDX_LEVEL) begin
        s_axi_rdata[6:0] <= fifo_count_r;
      end else if (rd_idx == rfb_pkg::IDX_WATER) begin
        s_axi_rdata[5:0] <= watermark_level_r;
      end else if (rd_idx == rfb_pkg::IDX_CTRL) begin
        s_axi_rdata[7:0] <= rfb_pkg::CTRL_RSVD |
                            {5'h00, rx_valid_last_bits_r};
      end else if (rd_idx == rfb_pkg::IDX_FRAME) begin
        s_axi_rdata[7:0] <= {1'b0, rx_bit_alignment_r, 1'b0,
                             tx_last_bits_b_r};
      end else if (rd_idx == rfb_pkg::IDX_ISTAT) begin
        s_axi_rdata[rfb_pkg::IRQ_W-1:0] <= istat_r;
      end else if (rd_idx == rfb_pkg::IDX_IMASK) begin
        s_axi_rdata[rfb_pkg::IRQ_W-1:0] <= imask_r;
      end else if (rd_idx == rfb_pkg::IDX_MODEM) begin
        s_axi_rdata[7:0] <= {1'b0, modem_state_c, buffer_overflow_error_r,
                             high_alert, low_alert, transceive_r};
      end else begin
        s_axi_rresp <= rfb_pkg::RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_push_count;
    host_push && !full && !pop && !flush |=>
      fifo_count_r == $past(fifo_count_r) + 7'h01;
  endproperty
  a_push_count: assert property (p_push_count)
    else $error("count not incremented on push");

  property p_pop_count;
    host_pop && !empty && !push && !flush |=>
      fifo_count_r == $past(fifo_count_r) - 7'h01;
  endproperty
  a_pop_count: assert property (p_pop_count)
    else $error("count not decremented on pop");

  property p_flush;
    flush |=> fifo_count_r == 7'h00 && !buffer_overflow_error_r
              && wr_ptr_r == rd_ptr_r;
  endproperty
  a_flush: assert property (p_flush)
    else $error("flush did not clear FIFO");

  property p_full_drop;
    host_push && full && !pop |=> fifo_count_r == rfb_pkg::FULL_CNT
                                  && buffer_overflow_error_r;
  endproperty
  a_full_drop: assert property (p_full_drop)
    else $error("write to full FIFO not dropped");

  property p_empty_read;
    host_pop && empty && !push && !flush |=> $stable(rd_ptr_r) && empty;
  endproperty
  a_empty_read: assert property (p_empty_read)
    else $error("empty read moved pointer");

  property p_level_read;
    do_rd && rd_idx == rfb_pkg::IDX_LEVEL && s_axi_araddr[11:10] == 2'h0
      |=> s_axi_rvalid && !s_axi_rdata[rfb_pkg::FLUSH_BIT]
          && s_axi_rdata[6:0] == $past(fifo_count_r);
  endproperty
  a_level_read: assert property (p_level_read)
    else $error("level read wrong");

  property p_alerts;
    high_alert == ((rfb_pkg::FULL_CNT - fifo_count_r)
                   <= 7'(watermark_level_r)) &&
    low_alert == (fifo_count_r <= 7'(watermark_level_r));
  endproperty
  a_alerts: assert property (p_alerts)
    else $error("alert relation broken");

  property p_low_rise;
    low_alert && !$past(low_alert) |=> istat_r[rfb_pkg::IRQ_LO];
  endproperty
  a_low_rise: assert property (p_low_rise)
    else $error("low alert rise not recorded");

  sequence s_start_wait;
    state_r == rfb_pkg::ST_WAIT && transceive_r && start_send_a;
  endsequence
  sequence s_in_tx;
    modem_state_c == rfb_pkg::MS_TX;
  endsequence
  property p_start;
    s_start_wait |=> s_in_tx;
  endproperty
  a_start: assert property (p_start)
    else $error("start-send did not leave wait state");

  property p_strobe;
    wr_ok && wr_idx == rfb_pkg::IDX_CTRL && wbyte[rfb_pkg::START_BIT]
      |=> timer_start_strobe ##1 !timer_start_strobe;
  endproperty
  a_strobe: assert property (p_strobe)
    else $error("timer start strobe not one pulse");

endmodule : rfb_top

// File: rtl/rfb_pkg.sv
// Constants for the reader FIFO and bit-framing block.
// Assumes an AXI4-Lite host with 32-bit data and a 25 MHz clock.
package rfb_pkg;
  // ----------------------------------------------------------------
  // FIFO geometry
  // ----------------------------------------------------------------
  localparam int         DEPTH   = 64;
  localparam int         PTR_W   = 6;
  localparam logic [6:0] FULL_CNT = 7'h40;
  // ----------------------------------------------------------------
  // Register indices; byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_DATA  = 8'h09;
  localparam logic [7:0] IDX_LEVEL = 8'h0a;
  localparam logic [7:0] IDX_WATER = 8'h0b;
  localparam logic [7:0] IDX_CTRL  = 8'h0c;
  localparam logic [7:0] IDX_FRAME = 8'h0d;
  localparam logic [7:0] IDX_ISTAT = 8'h10;
  localparam logic [7:0] IDX_IMASK = 8'h11;
  localparam logic [7:0] IDX_MODEM = 8'h12;
  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int         FLUSH_BIT  = 7;
  localparam int         STOP_BIT   = 7;
  localparam int         START_BIT  = 6;
  localparam int         SEND_BIT   = 7;
  localparam int         ALIGN_LSB  = 4;
  localparam int         XCV_BIT    = 0;
  localparam int         OVFL_BIT   = 3;
  localparam int         HI_BIT     = 1;
  localparam int         LO_BIT     = 0;
  localparam int         MST_LSB    = 4;
  localparam logic [5:0] WATER_RST  = 6'h08;
  localparam logic [7:0] CTRL_RSVD  = 8'h10;
  // Interrupt status bits
  localparam int         IRQ_W      = 4;
  localparam int         IRQ_OVFL   = 0;
  localparam int         IRQ_HI     = 1;
  localparam int         IRQ_LO     = 2;
  localparam int         IRQ_RXDONE = 3;
  // Modem state codes as shown to software
  localparam logic [2:0] MS_IDLE   = 3'h0;
  localparam logic [2:0] MS_WAIT   = 3'h1;
  localparam logic [2:0] MS_TX     = 3'h3;
  localparam logic [2:0] MS_RXWAIT = 3'h5;
  localparam logic [2:0] MS_RX     = 3'h6;
  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE, ST_WAIT, ST_TX, ST_RXWAIT, ST_RX
  } rfb_state_type;

  // Register index from a byte address
  function automatic logic [7:0] rfb_index(input logic [11:0] a);
    rfb_index = a[9:2];
  endfunction : rfb_index

  // Modem state code seen by software
  function automatic logic [2:0] rfb_code(input rfb_state_type s);
    case (s)
      ST_WAIT:   rfb_code = MS_WAIT;
      ST_TX:     rfb_code = MS_TX;
      ST_RXWAIT: rfb_code = MS_RXWAIT;
      ST_RX:     rfb_code = MS_RX;
      default:   rfb_code = MS_IDLE;
    endcase
  endfunction : rfb_code
endpackage : rfb_pkg

// File: test/rfb_radio.sv
// Radio-side partner for rfb_top: takes tx bits, sends rx bits.
// Assumes the shared aclk; the bench calls send from its main flow.
`timescale 1ns/10ps
module rfb_radio (
  input  wire logic aclk,
  input  wire logic tx_bit,
  input  wire logic tx_bit_valid,
  output logic      tx_bit_ready,
  output logic      rx_bit,
  output logic      rx_bit_valid,
  output logic      rx_end
);
  logic [31:0] got_bits = '0;
  int          n_got    = 0;
  initial {tx_bit_ready, rx_bit, rx_bit_valid, rx_end} = 4'h0;
  // Capture tx bits, stalling every other cycle
  always @(posedge aclk) begin
    tx_bit_ready <= ~tx_bit_ready;
    if (tx_bit_valid && tx_bit_ready) begin
      got_bits[n_got[4:0]] <= tx_bit;
      n_got                <= n_got + 1;
    end
  end
  // Rx frame LSB first, then frame end with the line flipped
  task automatic send(input logic [7:0] v, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge aclk);
      rx_bit       <= v[i];
      rx_bit_valid <= 1'b1;
    end
    @(posedge aclk);
    rx_bit       <= ~rx_bit;
    rx_bit_valid <= 1'b0;
    rx_end       <= 1'b1;
    @(posedge aclk);
    rx_end <= 1'b0;
  endtask : send
endmodule : rfb_radio

// File: test/rfb_top_tb.sv
// Self-checking bench for rfb_top over AXI4-Lite.
// Assumes rfb_radio on the bit ports and a 25 MHz aclk.
`timescale 1ns/10ps
module rfb_top_tb;
  logic        aclk = 0, aresetn = 0;
  logic [11:0] aw_addr = '0, ar_addr = '0;
  logic [31:0] w_data = '0, r_data;
  logic        aw_vld = 0, w_vld = 0, ar_vld = 0;
  logic        aw_rdy, w_rdy, b_vld, ar_rdy, r_vld, irq;
  logic [1:0]  b_resp, r_resp, r, rb;
  logic        t_go, t_stop, tx_b, tx_v, tx_r, rx_b, rx_v, rx_e;
  logic [2:0]  mstate;
  logic [7:0]  q [64];
  logic [7:0]  d, w, v;
  int          err_total = 0, n_compared = 0, cyc = 0, seed = 21921;
  int          n_go = 0, n_stop = 0;
  always #20 aclk = ~aclk;
  rfb_top u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(aw_addr),
    .s_axi_awvalid(aw_vld), .s_axi_awready(aw_rdy), .s_axi_wdata(w_data),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(w_vld), .s_axi_wready(w_rdy),
    .s_axi_bresp(b_resp), .s_axi_bvalid(b_vld), .s_axi_bready(1'b1),
    .s_axi_araddr(ar_addr), .s_axi_arvalid(ar_vld), .s_axi_arready(ar_rdy),
    .s_axi_rdata(r_data), .s_axi_rresp(r_resp), .s_axi_rvalid(r_vld),
    .s_axi_rready(1'b1), .irq(irq), .timer_start_strobe(t_go),
    .timer_stop_strobe(t_stop), .tx_bit(tx_b), .tx_bit_valid(tx_v),
    .tx_bit_ready(tx_r), .rx_bit(rx_b), .rx_bit_valid(rx_v),
    .rx_end(rx_e), .modem_state_c(mstate));
  rfb_radio u_radio (.aclk(aclk), .tx_bit(tx_b), .tx_bit_valid(tx_v),
    .tx_bit_ready(tx_r), .rx_bit(rx_b), .rx_bit_valid(rx_v), .rx_end(rx_e));
  // Report, verdict and stop
  task automatic end_sim;
    $display("compared %0d, errors %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  // Register write; aw and w released as each is taken
  task automatic wr(input logic [7:0] i, input logic [7:0] dv);
    logic a, b;
    a = 1;
    b = 1;
    aw_addr <= {2'h0, i, 2'h0};
    w_data  <= {24'h0, dv};
    aw_vld  <= 1'b1;
    w_vld   <= 1'b1;
    while (a || b) begin
      @(posedge aclk);
      if (a && aw_rdy) begin a = 0; aw_vld <= 1'b0; end
      if (b && w_rdy) begin b = 0; w_vld <= 1'b0; end
    end
    do @(posedge aclk); while (b_vld !== 1'b1);
    rb = b_resp;
  endtask : wr
  task automatic rd(input logic [7:0] i, output logic [7:0] dv);
    ar_addr <= {2'h0, i, 2'h0};
    ar_vld  <= 1'b1;
    do @(posedge aclk); while (ar_rdy !== 1'b1);
    ar_vld <= 1'b0;
    do @(posedge aclk); while (r_vld !== 1'b1);
    dv = r_data[7:0];
    r  = r_resp;
  endtask : rd
  // Expected overflow and alert bits of the modem register
  function automatic logic [7:0] exp_mod(input int k, input logic [7:0] wl);
    int n;
    n = (k > 64) ? 64 : k;
    return {4'h0, k > 64, 64 - n <= wl, n <= wl, 1'b0};
  endfunction : exp_mod
  // Strobe counters and hang limit
  always @(posedge aclk) begin
    n_go   += t_go;
    n_stop += t_stop;
    if (++cyc == 20000) begin err_total++; end_sim(); end
  end
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(rfb_pkg::IDX_LEVEL, d); chk(d, 8'h00);
    rd(rfb_pkg::IDX_WATER, d); chk(d, 8'h08);
    rd(rfb_pkg::IDX_CTRL, d); chk(d, 8'h10);
    rd(8'h3f, d); chk(r, rfb_pkg::RESP_SLVERR);
    wr(8'h3f, 8'h00); chk(rb, rfb_pkg::RESP_SLVERR);
    w = 8'($random(seed)) & 8'h3f;
    wr(rfb_pkg::IDX_WATER, w); chk(rb, rfb_pkg::RESP_OKAY);
    // Fill with 64 random bytes plus one 8'h5a past full, alerts after each write
    for (int k = 1; k <= 65; k++) begin
      if (k <= 64) q[k-1] = 8'($random(seed));
      wr(rfb_pkg::IDX_DATA, (k <= 64) ? q[k-1] : 8'h5a);
      rd(rfb_pkg::IDX_MODEM, d); chk(d & 8'h0e, exp_mod(k, w));
    end
    rd(rfb_pkg::IDX_LEVEL, d); chk(d, 8'h40);
    wr(rfb_pkg::IDX_IMASK, 8'h01);
    @(posedge aclk); chk(irq, 1'b1);
    wr(rfb_pkg::IDX_ISTAT, 8'h01);
    @(posedge aclk); chk(irq, 1'b0);
    for (int k = 0; k < 64; k++) begin
      rd(rfb_pkg::IDX_DATA, d); chk(d, q[k]);
    end
    rd(rfb_pkg::IDX_DATA, d); chk(d, 8'h00);
    rd(rfb_pkg::IDX_LEVEL, d); chk(d, 8'h00);
    // Flush with a byte held and overflow still set
    wr(rfb_pkg::IDX_DATA, 8'h11);
    wr(rfb_pkg::IDX_LEVEL, 8'h80);
    rd(rfb_pkg::IDX_LEVEL, d); chk(d, 8'h00);
    rd(rfb_pkg::IDX_MODEM, d); chk(d & 8'h08, 8'h00);
    wr(rfb_pkg::IDX_CTRL, 8'hc0);
    rd(rfb_pkg::IDX_CTRL, d); chk(d, 8'h10);
    chk(n_go, 1);
    chk(n_stop, 1);
    // Anticollision-style frame: three bits out, rx aligned at bit 3
    q[0] = 8'($random(seed));
    wr(rfb_pkg::IDX_DATA, q[0]);
    wr(rfb_pkg::IDX_FRAME, 8'hb3);
    @(posedge aclk); chk(mstate, rfb_pkg::MS_IDLE);
    wr(rfb_pkg::IDX_MODEM, 8'h01);
    repeat (3) @(posedge aclk); chk(mstate, rfb_pkg::MS_WAIT);
    wr(rfb_pkg::IDX_FRAME, 8'hb3);
    for (int k = 0; k < 200 && mstate !== rfb_pkg::MS_RXWAIT; k++)
      @(posedge aclk);
    chk(mstate, rfb_pkg::MS_RXWAIT);
    chk(u_radio.n_got, 3);
    chk(u_radio.got_bits[2:0], q[0][2:0]);
    rd(rfb_pkg::IDX_FRAME, d); chk(d, 8'h33);
    v = 8'($random(seed));
    u_radio.send(v, 7);
    repeat (2) @(posedge aclk);
    rd(rfb_pkg::IDX_LEVEL, d); chk(d, 8'h02);
    rd(rfb_pkg::IDX_DATA, d); chk(d & 8'hf8, {v[4:0], 3'h0});
    rd(rfb_pkg::IDX_DATA, d); chk(d & 8'h03, {6'h0, v[6:5]});
    rd(rfb_pkg::IDX_CTRL, d); chk(d, 8'h12);
    end_sim();
  end
endmodule : rfb_top_tb
